/* rtl/dsip_pkg.sv */
package dsip_pkg;

  localparam int WORD_W = 16;
  localparam int CODE_W = 12;
  localparam int CMD_W = 4;
  localparam int CMD_LSB = 12;
  localparam int FIFO_DEPTH = 4;
  localparam int CNT_W = 5;

  localparam logic [CNT_W-1:0] LAST_BIT = 5'h0f;
  localparam logic [CNT_W-1:0] BIT_CNT_MAX = 5'h10;

  localparam logic [CMD_W-1:0] CMD_NOP = 4'h0;
  localparam logic [CMD_W-1:0] CMD_LOAD = 4'h1;
  localparam logic [CMD_W-1:0] CMD_READBACK = 4'h2;
  localparam logic [CMD_W-1:0] CMD_EDGE_RISE = 4'h3;
  localparam logic [CMD_W-1:0] CMD_EDGE_FALL = 4'h4;

  localparam logic [WORD_W-1:0] SHIFT_RST = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_RST = 12'h000;
  localparam logic EDGE_RISE_RST = 1'b0;

  localparam int MCLK_PERIOD_NS = 40;
  localparam int HOST_SCLK_PERIOD_NS = 640;
  localparam int HOST_GAP_NS = 640;
  localparam int HALF_CYC = (HOST_SCLK_PERIOD_NS / 2) / MCLK_PERIOD_NS;
  localparam int GAP_CYC = (HOST_GAP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int TMR_W = 8;
  localparam logic [TMR_W-1:0] HALF_END = TMR_W'(HALF_CYC - 1);
  localparam logic [TMR_W-1:0] GAP_END = TMR_W'(GAP_CYC - 1);

  typedef enum logic [2:0] {
    DSIP_H_IDLE = 3'b000,
    DSIP_H_LEAD = 3'b001,
    DSIP_H_CAP = 3'b010,
    DSIP_H_TAIL = 3'b011,
    DSIP_H_GAP = 3'b100
  } dsip_hst_e;

endpackage

/* rtl/dsip_if.sv */
interface dsip_if;
  logic sync_n;
  logic sclk;
  logic serial_in_pin;
  logic serial_out_pin;

  modport host (
    output sync_n,
    output sclk,
    output serial_in_pin,
    input serial_out_pin
  );

  modport dev (
    input sync_n,
    input sclk,
    input serial_in_pin,
    output serial_out_pin
  );
endinterface

/* rtl/dsip_dev.sv */

module dsip_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [CW-1:0] cnt_ff;
  logic push;
  logic pop;

  assign in_ready = (cnt_ff != CW'(D));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem[rd_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ff <= '0;
    end else if (push) begin
      wr_ff <= (wr_ff == AW'(D - 1)) ? '0 : wr_ff + AW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_ff <= '0;
    end else if (pop) begin
      rd_ff <= (rd_ff == AW'(D - 1)) ? '0 : rd_ff + AW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (push && !pop) begin
      cnt_ff <= cnt_ff + CW'(1);
    end else if (pop && !push) begin
      cnt_ff <= cnt_ff - CW'(1);
    end
  end
endmodule

module dsip_dev (
  input wire logic mclk,
  input wire logic rst_n,
  dsip_if.dev link,
  input wire logic dac_accept,
  output logic [dsip_pkg::CODE_W-1:0] dac_code,
  output logic dac_load,
  output logic edge_rise,
  output logic overrun
);
  import dsip_pkg::*;

  logic sync_m_ff;
  logic sync_s_ff;
  logic sync_d_ff;
  logic sclk_m_ff;
  logic sclk_s_ff;
  logic sclk_d_ff;
  logic din_m_ff;
  logic din_s_ff;
  logic [WORD_W-1:0] shift_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic sdo_ff;
  logic edge_rise_ff;
  logic edge_act_ff;
  logic rb_pend_ff;
  logic [CODE_W-1:0] dac_ff;
  logic load_ff;
  logic overrun_ff;
  logic frame;
  logic frame_start;
  logic frame_end;
  logic sclk_rise;
  logic sclk_fall;
  logic cap_edge;
  logic out_edge;
  logic word_stb;
  logic [WORD_W-1:0] word_in;
  logic fifo_ready;
  logic fifo_valid;
  logic [WORD_W-1:0] fifo_word;
  logic [CMD_W-1:0] cmd;
  logic pop;

  // Every pin passes two flops; the third stage only serves edge detection.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync_m_ff <= 1'b1;
      sync_s_ff <= 1'b1;
      sync_d_ff <= 1'b1;
    end else begin
      sync_m_ff <= link.sync_n;
      sync_s_ff <= sync_m_ff;
      sync_d_ff <= sync_s_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sclk_m_ff <= 1'b1;
      sclk_s_ff <= 1'b1;
      sclk_d_ff <= 1'b1;
    end else begin
      sclk_m_ff <= link.sclk;
      sclk_s_ff <= sclk_m_ff;
      sclk_d_ff <= sclk_s_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      din_m_ff <= 1'b0;
      din_s_ff <= 1'b0;
    end else begin
      din_m_ff <= link.serial_in_pin;
      din_s_ff <= din_m_ff;
    end
  end

  assign frame = !sync_s_ff;
  assign frame_start = !sync_s_ff && sync_d_ff;
  assign frame_end = sync_s_ff && !sync_d_ff;
  assign sclk_rise = sclk_s_ff && !sclk_d_ff;
  assign sclk_fall = !sclk_s_ff && sclk_d_ff;
  assign cap_edge = edge_act_ff ? sclk_rise : sclk_fall;
  assign out_edge = edge_act_ff ? sclk_fall : sclk_rise;
  assign word_in = {shift_ff[WORD_W-2:0], din_s_ff};
  assign word_stb = frame && cap_edge && (cnt_ff == LAST_BIT);

  // Readback loads the DAC code when the frame closes, so the next frame shifts it out.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shift_ff <= SHIFT_RST;
    end else if (frame_end && rb_pend_ff) begin
      shift_ff <= {{CMD_W{1'b0}}, dac_ff};
    end else if (frame && cap_edge) begin
      shift_ff <= word_in;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (frame_start) begin
      cnt_ff <= '0;
    end else if (frame && cap_edge && cnt_ff != BIT_CNT_MAX) begin
      cnt_ff <= cnt_ff + CNT_W'(1);
    end
  end

  // The output shows the register MSB so a downstream part sees our old word.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sdo_ff <= 1'b0;
    end else if (frame_start || (frame && out_edge)) begin
      sdo_ff <= shift_ff[WORD_W-1];
    end
  end

  dsip_fifo #(
    .W(WORD_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rst_n(rst_n),
    .in_valid(word_stb),
    .in_ready(fifo_ready),
    .in_data(word_in),
    .out_valid(fifo_valid),
    .out_ready(dac_accept),
    .out_data(fifo_word)
  );

  assign pop = fifo_valid && dac_accept;
  assign cmd = fifo_word[CMD_LSB +: CMD_W];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      overrun_ff <= 1'b0;
    end else if (word_stb && !fifo_ready) begin
      overrun_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dac_ff <= CODE_RST;
      load_ff <= 1'b0;
    end else begin
      load_ff <= pop && (cmd == CMD_LOAD);
      if (pop && cmd == CMD_LOAD) begin
        dac_ff <= fifo_word[CODE_W-1:0];
      end
    end
  end

  // The edge setting changes only on a command and otherwise holds.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      edge_rise_ff <= EDGE_RISE_RST;
    end else if (pop) begin
      case (cmd)
        CMD_EDGE_RISE: edge_rise_ff <= 1'b1;
        CMD_EDGE_FALL: edge_rise_ff <= 1'b0;
        default: edge_rise_ff <= edge_rise_ff;
      endcase
    end
  end

  // The edge in use follows the setting only between frames, so no frame is split.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      edge_act_ff <= EDGE_RISE_RST;
    end else if (!frame) begin
      edge_act_ff <= edge_rise_ff;
    end
  end

  // A new readback request wins over the clear at frame end.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rb_pend_ff <= 1'b0;
    end else if (pop && cmd == CMD_READBACK) begin
      rb_pend_ff <= 1'b1;
    end else if (frame_end) begin
      rb_pend_ff <= 1'b0;
    end
  end

  assign link.serial_out_pin = sdo_ff;
  assign dac_code = dac_ff;
  assign dac_load = load_ff;
  assign edge_rise = edge_rise_ff;
  assign overrun = overrun_ff;
endmodule

/* rtl/dsip_host.sv */
module dsip_host (
  input wire logic mclk,
  input wire logic rst_n,
  dsip_if.host link,
  input wire logic start,
  input wire logic [dsip_pkg::WORD_W-1:0] tx_word,
  input wire logic cap_rise,
  output logic busy,
  output logic done,
  output logic [dsip_pkg::WORD_W-1:0] rx_word
);
  import dsip_pkg::*;

  dsip_hst_e st_ff;
  logic [TMR_W-1:0] tmr_ff;
  logic [WORD_W-1:0] sh_ff;
  logic [WORD_W-1:0] rx_ff;
  logic [WORD_W-1:0] rx_word_ff;
  logic [CNT_W-1:0] bit_ff;
  logic rise_ff;
  logic sync_ff;
  logic sclk_ff;
  logic serial_in_pin_ff;
  logic busy_ff;
  logic done_ff;
  logic sdo_m_ff;
  logic sdo_s_ff;
  logic tmr_end;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sdo_m_ff <= 1'b0;
      sdo_s_ff <= 1'b0;
    end else begin
      sdo_m_ff <= link.serial_out_pin;
      sdo_s_ff <= sdo_m_ff;
    end
  end

  assign tmr_end = (st_ff == DSIP_H_GAP) ? (tmr_ff == GAP_END) : (tmr_ff == HALF_END);

  always_ff @(posedge mclk) begin
    if (!rst_n || st_ff == DSIP_H_IDLE || tmr_end) begin
      tmr_ff <= '0;
    end else begin
      tmr_ff <= tmr_ff + TMR_W'(1);
    end
  end

  // Half period is long enough for the far end's output to cross both synchronisers.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= DSIP_H_IDLE;
      sync_ff <= 1'b1;
      sclk_ff <= 1'b1;
      serial_in_pin_ff <= 1'b0;
      sh_ff <= '0;
      rx_ff <= '0;
      bit_ff <= '0;
      rise_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      rx_word_ff <= '0;
    end else begin
      done_ff <= 1'b0;
      case (st_ff)
        DSIP_H_IDLE: begin
          sclk_ff <= !cap_rise;
          if (start) begin
            st_ff <= DSIP_H_LEAD;
            sync_ff <= 1'b0;
            sh_ff <= tx_word;
            serial_in_pin_ff <= tx_word[WORD_W-1];
            rise_ff <= cap_rise;
            bit_ff <= '0;
            busy_ff <= 1'b1;
          end
        end
        DSIP_H_LEAD: begin
          if (tmr_end) begin
            sclk_ff <= rise_ff;
            rx_ff <= {rx_ff[WORD_W-2:0], sdo_s_ff};
            st_ff <= DSIP_H_CAP;
          end
        end
        DSIP_H_CAP: begin
          if (tmr_end) begin
            sclk_ff <= !rise_ff;
            sh_ff <= {sh_ff[WORD_W-2:0], 1'b0};
            serial_in_pin_ff <= sh_ff[WORD_W-2];
            bit_ff <= bit_ff + CNT_W'(1);
            st_ff <= (bit_ff == LAST_BIT) ? DSIP_H_TAIL : DSIP_H_LEAD;
          end
        end
        DSIP_H_TAIL: begin
          if (tmr_end) begin
            sync_ff <= 1'b1;
            st_ff <= DSIP_H_GAP;
          end
        end
        DSIP_H_GAP: begin
          if (tmr_end) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
            rx_word_ff <= rx_ff;
            st_ff <= DSIP_H_IDLE;
          end
        end
        default: begin
          st_ff <= DSIP_H_IDLE;
        end
      endcase
    end
  end

  assign link.sync_n = sync_ff;
  assign link.sclk = sclk_ff;
  assign link.serial_in_pin = serial_in_pin_ff;
  assign busy = busy_ff;
  assign done = done_ff;
  assign rx_word = rx_word_ff;
endmodule

/* verif/dsip_asserts.sv */
module dsip_asserts (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_ff;
  logic sync_ff;
  logic [5:0] hist_ff;
  logic [5:0] edges_ff;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge mclk) begin
    sclk_ff <= sclk;
    sync_ff <= sync_n;
  end
  // Recent pin activity; the output may only move shortly after one.
  always_ff @(posedge mclk) begin
    hist_ff <= {hist_ff[4:0], (sclk != sclk_ff) || (sync_n != sync_ff)};
  end
  always_ff @(posedge mclk) begin
    if (!rst_n || sync_n) begin
      edges_ff <= 6'h00;
    end else if (sclk != sclk_ff) begin
      edges_ff <= edges_ff + 6'h01;
    end
  end

  property p_idle;
    $rose(rst_n) |-> sync_n && sclk;
  endproperty
  a_idle: assert property (p_idle) else $error("idle levels wrong");
  property p_lead;
    $fell(sync_n) |-> $stable(sclk)[*8];
  endproperty
  a_lead: assert property (p_lead) else $error("clock moved at frame open");
  property p_half;
    $changed(sclk) && !sync_n |=> $stable(sclk)[*7];
  endproperty
  a_half: assert property (p_half) else $error("clock half period short");
  property p_count;
    $rose(sync_n) |-> edges_ff == 6'h20;
  endproperty
  a_count: assert property (p_count) else $error("edge count per frame wrong");
  property p_hold;
    $fell(sync_n) |-> !sync_n[*8];
  endproperty
  a_hold: assert property (p_hold) else $error("frame select dropped");
  property p_gap;
    $rose(sync_n) |=> sync_n[*8];
  endproperty
  a_gap: assert property (p_gap) else $error("frame gap short");
  property p_out_src;
    $changed(serial_out_pin) |-> hist_ff != 6'h00;
  endproperty
  a_out_src: assert property (p_out_src) else $error("output moved without edge");
  property p_quiet;
    $changed(sclk) |=> $stable(serial_out_pin)[*2];
  endproperty
  a_quiet: assert property (p_quiet) else $error("output moved too soon");
endmodule

/* verif/dsip_tb.sv */
module dsip_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dsip_pkg::*;
  logic mclk, rst_n, start, cap_rise, dac_accept;
  logic busy, done, dac_load, edge_rise, overrun;
  logic [WORD_W-1:0] tx_word, rx_word, prev, lfsr;
  logic [CODE_W-1:0] dac_code, code, keep;
  int fail_count, tests_run, n;

  dsip_if dsip_if_i ();
  dsip_dev dsip_dev_i (.mclk(mclk), .rst_n(rst_n), .link(dsip_if_i),
    .dac_accept(dac_accept), .dac_code(dac_code), .dac_load(dac_load),
    .edge_rise(edge_rise), .overrun(overrun));
  dsip_host dsip_host_i (.mclk(mclk), .rst_n(rst_n), .link(dsip_if_i), .start(start),
    .tx_word(tx_word), .cap_rise(cap_rise), .busy(busy), .done(done), .rx_word(rx_word));
  dsip_asserts dsip_asserts_i (.mclk(mclk), .rst_n(rst_n), .sync_n(dsip_if_i.sync_n),
    .sclk(dsip_if_i.sclk), .serial_in_pin(dsip_if_i.serial_in_pin),
    .serial_out_pin(dsip_if_i.serial_out_pin));

  function automatic logic [15:0] step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [15:0] code_word(input logic [11:0] c);
    return {4'h0, c};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The word echoed back is whatever the previous frame left in the shift register.
  task automatic frame(input logic [15:0] w);
    int k;
    @(negedge mclk);
    tx_word = w;
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    chk({15'h0000, busy}, 16'h0001);
    k = 0;
    while (done !== 1'b1 && k < 600) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 600) begin
      fail_count++;
      conclude();
    end
    chk({15'h0000, busy}, 16'h0000);
    chk(rx_word, prev);
    prev = w;
  endtask

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    #1000000;
    fail_count++;
    conclude();
  end

  initial begin
    fail_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    start = 1'b0;
    tx_word = 16'h0000;
    cap_rise = 1'b0;
    dac_accept = 1'b1;
    prev = SHIFT_RST;
    lfsr = 16'h97fa;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    chk({4'h0, dac_code}, {4'h0, CODE_RST});
    chk({15'h0000, edge_rise}, {15'h0000, EDGE_RISE_RST});
    $display("reset test over");
    for (int i = 0; i < 6; i++) begin
      lfsr = step(lfsr);
      code = (i == 0) ? 12'hfff : lfsr[11:0];
      frame({CMD_LOAD, code});
      chk({4'h0, dac_code}, {4'h0, code});
    end
    $display("load test over");
    frame({CMD_READBACK, 12'h000});
    prev = code_word(code);
    frame({CMD_NOP, 12'h5a5});
    $display("readback test over");
    frame({CMD_EDGE_RISE, 12'h000});
    chk({15'h0000, edge_rise}, 16'h0001);
    cap_rise = 1'b1;
    repeat (4) @(negedge mclk);
    for (int i = 0; i < 3; i++) begin
      lfsr = step(lfsr);
      code = lfsr[11:0];
      frame({CMD_LOAD, code});
      chk({4'h0, dac_code}, {4'h0, code});
      chk({15'h0000, edge_rise}, 16'h0001);
    end
    frame({CMD_EDGE_FALL, 12'h000});
    chk({15'h0000, edge_rise}, 16'h0000);
    cap_rise = 1'b0;
    repeat (4) @(negedge mclk);
    $display("edge test over");
    dac_accept = 1'b0;
    for (int i = 0; i < 5; i++) begin
      lfsr = step(lfsr);
      if (i == 3) keep = lfsr[11:0];
      frame({CMD_LOAD, lfsr[11:0]});
      chk({15'h0000, overrun}, (i == 4) ? 16'h0001 : 16'h0000);
    end
    dac_accept = 1'b1;
    n = 0;
    repeat (12) begin
      @(negedge mclk);
      if (dac_load === 1'b1) n++;
    end
    chk(n[15:0], 16'h0004);
    chk({4'h0, dac_code}, {4'h0, keep});
    $display("fifo test over");
    conclude();
  end
endmodule
